// File: can_mailbox_tx_rx_status.v
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "can_mbox_flags_map.vh"

module can_mailbox_tx_rx_status #(
   parameter NUM_MBOX = 16
) (
   input wire i_clk,
   input wire i_srst,
   // Avalon-MM slave, word addressed
   input wire [3:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // Protocol engine side, indexed by mailbox number
   input wire [NUM_MBOX-1:0] i_tx_wait,
   input wire [NUM_MBOX-1:0] i_tx_sent,
   input wire [NUM_MBOX-1:0] i_rx_data,
   input wire [NUM_MBOX-1:0] i_rx_remote,
   output reg [NUM_MBOX-1:0] o_wait_clear,
   output reg o_receive_message_irq_flag,
   output reg o_remote_request_irq_flag,
   output reg o_irq
);

   // Flag registers kept in software bit order
   reg [15:0] cancel_q;
   reg [15:0] cancel_d;
   reg [15:0] tx_done_q;
   reg [15:0] tx_done_d;
   reg [15:0] abort_done_q;
   reg [15:0] abort_done_d;
   reg [15:0] rx_done_q;
   reg [15:0] rx_done_d;
   reg [15:0] remote_q;
   reg [15:0] remote_d;
   reg [15:0] mbox_mask_q;
   reg [15:0] mbox_mask_d;
   reg [`IRQ_BITS-1:0] irq_stat_q;
   reg [`IRQ_BITS-1:0] irq_stat_d;
   reg [`IRQ_BITS-1:0] irq_mask_q;
   reg [`IRQ_BITS-1:0] irq_mask_d;
   reg [31:0] rdata_d;

   // Engine inputs swapped into register bit order
   wire [15:0] wait_r;
   wire [15:0] sent_r;
   wire [15:0] rxd_r;
   wire [15:0] rxr_r;

   // Bus qualifiers
   wire rd_take;
   wire wr_take;
   wire [15:0] wmask;
   wire [15:0] wdata;
   wire [15:0] w1;

   // Hardware events
   wire [15:0] abort_evt;
   wire [15:0] cancel_set;
   wire [15:0] rx_evt;
   wire [15:0] rx_unmasked;
   wire [15:0] rem_unmasked;
   wire [`IRQ_BITS-1:0] irq_evt;

   // Per-bit swap: bit b holds mailbox (b+8) mod 16
   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1) begin : g_swap
         assign wait_r[b] = i_tx_wait[(b + 8) % 16]; // R1 R10
         assign sent_r[b] = i_tx_sent[(b + 8) % 16]; // R1
         assign rxd_r[b] = i_rx_data[(b + 8) % 16]; // R10
         assign rxr_r[b] = i_rx_remote[(b + 8) % 16]; // R10
      end
   endgenerate

   // One wait state: access commits where waitrequest is low
   assign rd_take = i_avs_read & ~o_avs_waitrequest;
   assign wr_take = i_avs_write & ~o_avs_waitrequest;
   assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   assign wdata = i_avs_writedata[15:0] & wmask;
   assign w1 = wr_take ? wdata : 16'h0000;

   // Cancel only takes on a mailbox that is actually waiting
   assign cancel_set = (i_avs_address == `OFS_CANCEL) ? (w1 & wait_r & `TX_BIT_MASK) : 16'h0000; // R3 R2

   // Cancellation done when wait drops without a send in the same cycle
   assign abort_evt = cancel_q & ~wait_r & ~sent_r & `TX_BIT_MASK; // R6 R16

   // Remote frames count as receptions too
   assign rx_evt = rxd_r | rxr_r; // R9
   assign rx_unmasked = rx_evt & ~mbox_mask_q; // R14
   assign rem_unmasked = rxr_r & ~mbox_mask_q; // R15

   assign irq_evt[`IRQ_TX_DONE] = |(sent_r & `TX_BIT_MASK);
   assign irq_evt[`IRQ_ABORT_DONE] = |abort_evt;
   assign irq_evt[`IRQ_RX_DONE] = |rx_unmasked;
   assign irq_evt[`IRQ_REMOTE] = |rem_unmasked;

   // Next state of all flags; set beats a same-cycle clear
   always @* begin
      cancel_d = cancel_q;
      tx_done_d = tx_done_q;
      abort_done_d = abort_done_q;
      rx_done_d = rx_done_q;
      remote_d = remote_q;
      mbox_mask_d = mbox_mask_q;
      irq_stat_d = irq_stat_q;
      irq_mask_d = irq_mask_q;
      // Cancel self-clears once transmit-wait has gone
      cancel_d = ((cancel_q & wait_r) | cancel_set) & `TX_BIT_MASK; // R3 R4 R13
      if (i_avs_address == `OFS_TX_DONE) begin
         tx_done_d = tx_done_q & ~w1; // R5
      end
      tx_done_d = (tx_done_d | sent_r) & `TX_BIT_MASK; // R5 R17 R2
      if (i_avs_address == `OFS_ABORT_DONE) begin
         abort_done_d = abort_done_q & ~w1; // R6
      end
      abort_done_d = (abort_done_d | abort_evt) & `TX_BIT_MASK; // R6 R17 R16
      if (i_avs_address == `OFS_RX_DONE) begin
         rx_done_d = rx_done_q & ~w1; // R7
      end
      rx_done_d = rx_done_d | rx_evt; // R7 R9 R17
      if (i_avs_address == `OFS_REMOTE) begin
         remote_d = remote_q & ~w1; // R8
      end
      remote_d = remote_d | rxr_r; // R8 R9 R17
      if (wr_take && i_avs_address == `OFS_MBOX_MASK) begin
         mbox_mask_d = (mbox_mask_q & ~wmask) | wdata;
      end
      if (i_avs_address == `OFS_IRQ_STATUS) begin
         irq_stat_d = irq_stat_q & ~w1[`IRQ_BITS-1:0];
      end
      irq_stat_d = irq_stat_d | irq_evt; // R17
      if (wr_take && i_avs_address == `OFS_IRQ_MASK) begin
         irq_mask_d = (irq_mask_q & ~wmask[`IRQ_BITS-1:0]) | wdata[`IRQ_BITS-1:0];
      end
   end

   // Read mux, unmapped words read zero
   always @* begin
      rdata_d = 32'h00000000;
      if (i_avs_address == `OFS_CANCEL) begin
         rdata_d[15:0] = cancel_q & `TX_BIT_MASK; // R2 R12
      end else if (i_avs_address == `OFS_TX_DONE) begin
         rdata_d[15:0] = tx_done_q & `TX_BIT_MASK; // R2
      end else if (i_avs_address == `OFS_ABORT_DONE) begin
         rdata_d[15:0] = abort_done_q & `TX_BIT_MASK; // R2
      end else if (i_avs_address == `OFS_RX_DONE) begin
         rdata_d[15:0] = rx_done_q; // R10
      end else if (i_avs_address == `OFS_REMOTE) begin
         rdata_d[15:0] = remote_q; // R10
      end else if (i_avs_address == `OFS_WAIT_VIEW) begin
         rdata_d[15:0] = wait_r & `TX_BIT_MASK;
      end else if (i_avs_address == `OFS_MBOX_MASK) begin
         rdata_d[15:0] = mbox_mask_q;
      end else if (i_avs_address == `OFS_IRQ_STATUS) begin
         rdata_d[`IRQ_BITS-1:0] = irq_stat_q;
      end else if (i_avs_address == `OFS_IRQ_MASK) begin
         rdata_d[`IRQ_BITS-1:0] = irq_mask_q;
      end else if (i_avs_address == `OFS_SUMMARY) begin
         rdata_d[`SUM_RX] = o_receive_message_irq_flag;
         rdata_d[`SUM_REMOTE] = o_remote_request_irq_flag;
      end
   end

   // Flag and mask state
   always @(posedge i_clk) begin
      if (i_srst) begin
         cancel_q <= `FLAGS_RESET; // R11
         tx_done_q <= `FLAGS_RESET; // R11
         abort_done_q <= `FLAGS_RESET; // R11
         rx_done_q <= `FLAGS_RESET; // R11
         remote_q <= `FLAGS_RESET; // R11
         mbox_mask_q <= `FLAGS_RESET;
         irq_stat_q <= `IRQ_RESET;
         irq_mask_q <= `IRQ_RESET;
      end else begin
         cancel_q <= cancel_d;
         tx_done_q <= tx_done_d;
         abort_done_q <= abort_done_d;
         rx_done_q <= rx_done_d;
         remote_q <= remote_d;
         mbox_mask_q <= mbox_mask_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // Bus handshake: drop waitrequest for exactly one cycle per request
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else begin
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
         if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= rdata_d; // Captured one edge before it is taken
         end
      end
   end

   // Engine and interrupt outputs, all registered
   always @(posedge i_clk) begin
      if (i_srst) begin
         o_wait_clear <= {NUM_MBOX{1'b0}};
         o_receive_message_irq_flag <= 1'b0;
         o_remote_request_irq_flag <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         // Asks the engine to drop transmit-wait while cancel is pending
         o_wait_clear <= {cancel_d[7:0], cancel_d[15:8]} & i_tx_wait; // R13 R1
         if (|rx_unmasked) begin
            o_receive_message_irq_flag <= 1'b1; // R14
         end else if ((rx_done_d & ~mbox_mask_d) == 16'h0000) begin
            o_receive_message_irq_flag <= 1'b0; // R14
         end
         if (|rem_unmasked) begin
            o_remote_request_irq_flag <= 1'b1; // R15
         end else if (remote_d == 16'h0000) begin
            o_remote_request_irq_flag <= 1'b0; // R15
         end
         o_irq <= |(irq_stat_d & irq_mask_d);
      end
   end

endmodule // can_mailbox_tx_rx_status

// File: can_mbox_flags_map.vh
// Contract
// [R1] Transmit flag bits 15..9 are mailboxes 7..1, bits 7..0 are mailboxes 15..8.
// [R2] Bit 8 of cancel, transmit-done and abort-done reads zero; software writes zero.
// [R3] Writing one to a cancel bit cancels that mailbox's pending transmission.
// [R4] Cancel bit self-clears once the transmit-wait bit has been cleared.
// [R5] Transmit-done flag sets on normal transmission, clears only by writing one.
// [R6] Abort-done flag sets on completed cancellation, clears only by writing one.
// [R7] Receive-done flag sets on data or remote frame reception, cleared by writing one.
// [R8] Remote-request flag sets on remote frame reception, cleared by writing one.
// [R9] A remote frame sets both remote-request and receive-done flags together.
// [R10] Receive registers use all 16 bits; mailbox 0 sits at bit 8.
// [R11] All five flag registers read zero after reset.
// [R12] Each register is 16 bits wide, readable and writable.
// [R13] Transmit-wait clears on transmission completion or cancellation completion.
// [R14] Receive summary flag sets on unmasked reception, clears when unmasked receive bits clear.
// [R15] Remote summary flag sets on unmasked remote reception, clears when remote bits clear.
// [R16] Per pending message exactly one of transmit-done or abort-done is set.
// [R17] Hardware set wins over a same-cycle software write-one clear.
`ifndef CAN_MBOX_FLAGS_MAP_VH
`define CAN_MBOX_FLAGS_MAP_VH

// Word offsets on the register bus
`define OFS_CANCEL 4'h0
`define OFS_TX_DONE 4'h1
`define OFS_ABORT_DONE 4'h2
`define OFS_RX_DONE 4'h3
`define OFS_REMOTE 4'h4
`define OFS_WAIT_VIEW 4'h5
`define OFS_MBOX_MASK 4'h6
`define OFS_IRQ_STATUS 4'h7
`define OFS_IRQ_MASK 4'h8
`define OFS_SUMMARY 4'h9

// Mailbox 0 has no transmit function: bit 8 reserved
`define TX_BIT_MASK 16'hfeff
`define FLAGS_RESET 16'h0000

// Interrupt status bit positions
`define IRQ_TX_DONE 0
`define IRQ_ABORT_DONE 1
`define IRQ_RX_DONE 2
`define IRQ_REMOTE 3
`define IRQ_BITS 4
`define IRQ_RESET 4'h0

// Summary register bit positions
`define SUM_RX 0
`define SUM_REMOTE 1

`endif

// File: can_mbox_chk_properties.sv
`timescale 1ns/1ps
`include "can_mbox_flags_map.vh"
// Watches the status block from its ports only
module can_mbox_chk #(
   parameter NUM_MBOX = 16
) (
   input wire i_clk,
   input wire i_srst,
   input wire [3:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire [NUM_MBOX-1:0] i_rx_data,
   input wire [NUM_MBOX-1:0] i_rx_remote,
   input wire [NUM_MBOX-1:0] o_wait_clear,
   input wire o_receive_message_irq_flag,
   input wire o_remote_request_irq_flag,
   input wire o_irq
);
   // Both summary flags lag their event by one register stage, so one past depth covers it; chk_rx_cause also accepts depth two, chk_rf_cause uses one
   wire req = i_avs_read | i_avs_write;
   wire rd_ok = i_avs_read & ~o_avs_waitrequest;
   wire rx = |(i_rx_data | i_rx_remote);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   chk_rst_idle: assert property ($fell(i_srst) |-> o_avs_waitrequest && !o_irq) else $error("busy after reset");
   chk_one_wait: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
   chk_rd_high: assert property (rd_ok |-> o_avs_readdata[31:16] == 16'h0000) else $error("upper bits set");
   chk_rd_bit8: assert property (rd_ok && i_avs_address < `OFS_RX_DONE |-> !o_avs_readdata[8]) else $error("bit8");
   chk_mbox0_idle: assert property (!o_wait_clear[0]) else $error("mailbox 0 cancel");
   chk_rx_cause: assert property ($rose(o_receive_message_irq_flag) |-> $past(rx) || $past(rx, 2)) else $error("rx");
   chk_rf_cause: assert property ($rose(o_remote_request_irq_flag) |-> $past(|i_rx_remote)) else $error("rf");
   chk_irq_fall: assert property ($fell(o_irq) |-> $past(i_avs_write) || $past(i_avs_write, 2)) else $error("irq");
   cover property (|i_rx_remote);
   cover property ($rose(o_irq));
   cover property (o_wait_clear != 0);
endmodule // can_mbox_chk
bind can_mailbox_tx_rx_status can_mbox_chk #(.NUM_MBOX(NUM_MBOX)) can_mbox_chk_i (.*);

// File: can_engine_model.sv
`timescale 1ns/1ps
// Protocol engine stand-in holding transmit-wait per mailbox
module can_engine_model (
   input wire i_clk,
   input wire i_srst,
   input wire i_slow,
   input wire [15:0] i_load,
   input wire [15:0] i_send,
   input wire [15:0] i_wait_clear,
   output reg [15:0] o_tx_wait,
   output reg [15:0] o_tx_sent
);
   reg tog_q;
   // A slow engine honours a cancel only on alternate cycles
   always @(posedge i_clk) begin
      tog_q <= ~tog_q & ~i_srst;
      o_tx_sent <= i_srst ? 16'h0000 : i_send & o_tx_wait;
      o_tx_wait <= i_srst ? 16'h0000 : (o_tx_wait | i_load) & ~i_send & ~(i_wait_clear & {16{~i_slow | tog_q}});
   end
endmodule // can_engine_model

// File: can_mailbox_tx_rx_status_tb.sv
`timescale 1ns/1ps
`include "can_mbox_flags_map.vh"
module can_mailbox_tx_rx_status_tb;
   reg i_clk = 0, i_srst = 1, i_avs_read = 0, i_avs_write = 0, slow = 0;
   reg [3:0] i_avs_address = 0;
   reg [31:0] i_avs_writedata = 0, q;
   reg [15:0] i_rx_data = 0, i_rx_remote = 0, ld = 0, snd = 0, erx = 0, erf = 0, etx = 0, eab = 0, v;
   reg [4:0] m;
   reg rs = 1'b0;
   wire [3:0] i_avs_byteenable = 4'hf;
   wire [31:0] o_avs_readdata;
   wire [15:0] i_tx_wait, i_tx_sent, o_wait_clear;
   wire o_avs_waitrequest, o_receive_message_irq_flag, o_remote_request_irq_flag, o_irq;
   integer n_errors = 0, n_compared = 0, cyc = 0, seed = 32'hb317592f, i;
   can_mailbox_tx_rx_status can_mailbox_tx_rx_status_i (.*);
   can_engine_model can_engine_model_i (.i_clk, .i_srst, .i_slow(slow), .i_load(ld), .i_send(snd),
      .i_wait_clear(o_wait_clear), .o_tx_wait(i_tx_wait), .o_tx_sent(i_tx_sent));
   initial forever #20 i_clk = ~i_clk;
   // Register bit order is the mailbox vector with its bytes swapped
   function [15:0] sw(input [15:0] x);
      sw = {x[7:0], x[15:8]};
   endfunction
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
      n_compared = n_compared + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
   endtask
   // One access, held until waitrequest is sampled low
   task bus(input w, input [3:0] a, input [15:0] d);
      @(posedge i_clk);
      {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, ~w, a, 16'h0000, d};
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
      q = o_avs_readdata;
      {i_avs_write, i_avs_read} <= 2'h0;
   endtask
   task rdc(input [63:0] nm, input [3:0] a, input [15:0] e);
      bus(0, a, 16'h0000);
      chk(nm, e, q[15:0]);
   endtask
   // One-cycle engine pulses: load, send, data frame, remote frame
   task ev(input [15:0] l, input [15:0] s, input [15:0] d, input [15:0] r);
      @(posedge i_clk);
      {ld, snd, i_rx_data, i_rx_remote} <= {l, s, d, r};
      @(posedge i_clk);
      {ld, snd, i_rx_data, i_rx_remote} <= 64'h0;
   endtask
   task close_out;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Ceiling well above the thousand-odd cycles the run needs
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_errors = n_errors + 1;
         close_out;
      end
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
         rdc("reset", i, 16'h0000);
      bus(1, 4'hf, 16'hffff);
      rdc("unmapped", 4'hf, 16'h0000);
      bus(1, `OFS_IRQ_MASK, 16'h0004);
      // Random frames into random mailboxes, then random write-one clears
      for (i = 0; i < 40; i = i + 1) begin
         m = $random(seed);
         v = 16'h0001 << m[3:0];
         ev(0, 0, m[4] ? 16'h0000 : v, m[4] ? v : 16'h0000);
         erx = erx | v;
         erf = m[4] ? erf | v : erf;
         rs = rs | m[4];
         rdc("rx_done", `OFS_RX_DONE, sw(erx));
         rdc("remote", `OFS_REMOTE, sw(erf));
         chk("summary", {|erx, |erf}, {o_receive_message_irq_flag, o_remote_request_irq_flag});
         chk("irq", 1, o_irq);
         v = $random(seed);
         bus(1, `OFS_RX_DONE, v);
         bus(1, `OFS_REMOTE, v);
         erx = erx & ~sw(v);
         erf = erf & ~sw(v);
      end
      // Mask, then clear, the pending receive interrupt
      bus(1, `OFS_IRQ_MASK, 16'h0000);
      // Remote frames also latch their own status bit
      rdc("irq_stat", `OFS_IRQ_STATUS, {12'h000, rs, 3'b100});
      chk("irq_mask", 0, o_irq);
      bus(1, `OFS_IRQ_STATUS, 16'h000f);
      bus(1, `OFS_IRQ_MASK, 16'h0004);
      rdc("irq_stat", `OFS_IRQ_STATUS, 16'h0000);
      chk("irq_clr", 0, o_irq);
      // Frame on mailbox 3 lands on the edge that takes its clear
      fork
         bus(1, `OFS_RX_DONE, 16'h0800);
         begin
            repeat (2) @(posedge i_clk);
            i_rx_data <= 16'h0008;
            @(posedge i_clk);
            i_rx_data <= 16'h0000;
         end
      join
      rdc("set_wins", `OFS_RX_DONE, sw(erx | 16'h0008));
      // Masked mailbox: flag sets, summary stays quiet
      bus(1, `OFS_RX_DONE, 16'hffff);
      bus(1, `OFS_REMOTE, 16'hffff);
      bus(1, `OFS_MBOX_MASK, 16'h0800);
      ev(0, 0, 16'h0008, 0);
      rdc("masked_rx", `OFS_RX_DONE, 16'h0800);
      chk("mask_sum", 0, o_receive_message_irq_flag);
      chk("rem_sum", 0, o_remote_request_irq_flag);
      bus(1, `OFS_MBOX_MASK, 16'h0000);
      // Sends and cancels on mailboxes 1 to 15 with a prompt or slow engine
      for (i = 0; i < 24; i = i + 1) begin
         m = $random(seed);
         v = 16'h0001 << (m[3:0] + (m[3:0] == 4'h0));
         slow <= m[4];
         // Send follows the load: a same-cycle send finds nothing waiting
         ev(v | (16'h0001 & {16{i[1]}}), 0, 0, 0);
         if (i[0])
            ev(0, v, 0, 0);
         if (!i[0])
            bus(1, `OFS_CANCEL, 16'hffff);
         etx = i[0] ? etx | v : etx;
         eab = i[0] ? eab : eab | v;
         while ((i_tx_wait & 16'hfffe) !== 16'h0000) @(posedge i_clk);
         repeat (2) @(posedge i_clk);
         rdc("cancel", `OFS_CANCEL, 16'h0000);
         rdc("tx_done", `OFS_TX_DONE, sw(etx));
         rdc("abort", `OFS_ABORT_DONE, sw(eab));
         v = $random(seed);
         bus(1, `OFS_TX_DONE, v);
         bus(1, `OFS_ABORT_DONE, v);
         etx = etx & ~sw(v);
         eab = eab & ~sw(v);
      end
      close_out;
   end
endmodule // can_mailbox_tx_rx_status_tb
